// ### hdl/sms_sequencer.sv
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "sms_params.svh"
// Behaviour
// - after reset the selection is erase-program-verify
// - mode key steps through the five modes in a fixed ring
// - one led per mode shows the selection while idle
// - enter key starts the selected operation
// - led of the running operation blinks
// - operations other than erase and load before a completed load are refused and error led blinks
// - combined operation blank checks, then erases if needed, then programs
// - no checksum is taken on a loaded image
// - access led lit during every master rom access
// - in load mode only the load led is lit
// - a failed load shows only on the error led
// - each rom access first reads the signature, mismatch rejects the rom
// - byte-wide eprom: twenty address lines, low enables, eight data lines
// - top two address lines unused for the smaller sockets
// - load starts by host command or enter key identically
module sms_sequencer #(
	parameter int ADDR_W = 20,
	parameter logic [15:0] SIG_EXPECT = 16'hA55A, // arbitrary value
	parameter int BLINK_HALF = `SMS_BLINK_HALF
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic mode_key,
	input wire logic enter_key,
	output logic [4:0] mode_led,
	output logic error_led,
	output logic access_led,
	output logic [ADDR_W-1:0] rom_address,
	output logic rom_ce_n,
	output logic rom_oe_n,
	input wire logic [7:0] rom_data,
	output logic [7:0] img_data,
	output logic img_valid,
	output logic [2:0] op_req,
	input wire logic op_done,
	input wire logic op_fail,
	input wire logic blank_ok,
	output logic irq,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import sms_pkg::*;
	localparam int ACC_CYC = (`SMS_ACC_NS * `SMS_CLK_MHZ + 999) / 1000;
	// refuse parameter values the logic cannot serve
	if (ADDR_W != 20) $error("rom address must be twenty bits");
	if (ACC_CYC < 1 || ACC_CYC > 255) $error("bad access count");
	if (BLINK_HALF < 1 || BLINK_HALF > `SMS_BLINK_HALF) $error("blink half period out of range");

	sms_mode_t mode_reg;
	sms_state_t state_reg;
	sms_phase_t phase_reg;
	logic loaded_reg, err_reg, mk_reg, ek_reg, blink_reg, aw_reg, w_reg, rd_hi_reg;
	logic [19:0] blink_cnt_reg;
	logic [7:0] wait_reg;
	logic [19:0] len_reg, cnt_reg;
	logic [15:0] sig_reg;
	logic [1:0] size_reg;
	logic [2:0] irq_reg, mask_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic mode_press, enter_press, host_load, load_go, wr_fire, last, sample_now, sig_bad;
	logic [2:0] ev;

	// key edge detect
	always_ff @(posedge clk) begin
		mk_reg <= srst ? 1'b0 : mode_key;
		ek_reg <= srst ? 1'b0 : enter_key;
	end
	assign mode_press = mode_key & ~mk_reg;
	assign enter_press = enter_key & ~ek_reg;

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	assign s_axi_awready = ~aw_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_reg & ~s_axi_bvalid;
	assign s_axi_bresp = 2'h0;
	assign wr_fire = aw_reg & w_reg & ~s_axi_bvalid;
	// capture address and data in either order
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_reg <= 1'b0;
			w_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_reg <= 1'b0;
				w_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// read channel, unmapped reads zero with okay
	assign s_axi_arready = ~s_axi_rvalid;
	assign s_axi_rresp = 2'h0;
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				`SMS_OFF_CTRL: s_axi_rdata <= {26'h0, size_reg, 4'h0};
				`SMS_OFF_STAT: s_axi_rdata <= {24'h0, err_reg, loaded_reg, 3'(state_reg), 3'(mode_reg)};
				`SMS_OFF_IRQ: s_axi_rdata <= {29'h0, irq_reg};
				`SMS_OFF_MASK: s_axi_rdata <= {29'h0, mask_reg};
				`SMS_OFF_SIG: s_axi_rdata <= {16'h0, sig_reg};
				`SMS_OFF_LEN: s_axi_rdata <= {12'h0, len_reg};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// config registers
	always_ff @(posedge clk) begin
		if (srst) begin
			mask_reg <= 3'h0;
			size_reg <= `SMS_SIZE_1M;
			len_reg <= `SMS_LEN_RST;
		end else if (wr_fire && s_axi_wstrb[0]) begin
			if (awaddr_reg == `SMS_OFF_MASK) mask_reg <= wdata_reg[2:0];
			if (awaddr_reg == `SMS_OFF_CTRL) size_reg <= wdata_reg[`SMS_CTRL_SIZE_HI:`SMS_CTRL_SIZE_LO];
			if (awaddr_reg == `SMS_OFF_LEN) len_reg <= wdata_reg[19:0];
		end
	end
	// host load command takes the same path as the key
	assign host_load = wr_fire && awaddr_reg == `SMS_OFF_CTRL && wdata_reg[`SMS_CTRL_LOAD];
	assign load_go = state_reg == ST_IDLE && (host_load || (enter_press && mode_reg == SMS_LOAD));

	// ------------------------------------------------------------
	// mode selection and sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) mode_reg <= SMS_EPV;
		else if (mode_press && state_reg == ST_IDLE) begin
			case (mode_reg)
				SMS_EPV: mode_reg <= SMS_ERASE;
				SMS_ERASE: mode_reg <= SMS_PROG;
				SMS_PROG: mode_reg <= SMS_VERIFY;
				SMS_VERIFY: mode_reg <= SMS_LOAD;
				default: mode_reg <= SMS_EPV;
			endcase
		end
	end
	assign last = cnt_reg == len_reg - 20'h1;
	// operations and rom reads; stored target settings used as is no checksum
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_NONE;
			loaded_reg <= 1'b0;
			err_reg <= 1'b0;
			cnt_reg <= 20'h0;
			wait_reg <= 8'h0;
			sig_reg <= `SMS_SIG_RST;
			rom_address <= 20'h0;
			img_data <= 8'h0;
			img_valid <= 1'b0;
			rd_hi_reg <= 1'b0;
		end else begin
			img_valid <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (load_go) begin
						state_reg <= ST_SIG;
						err_reg <= 1'b0;
						loaded_reg <= 1'b0;
						rom_address <= 20'h0;
						wait_reg <= 8'h0;
						rd_hi_reg <= 1'b0;
					end else if (enter_press) begin
						err_reg <= 1'b0;
						if (mode_reg != SMS_ERASE && !loaded_reg) state_reg <= ST_ERR;
						else begin
							state_reg <= ST_RUN;
							case (mode_reg)
								SMS_EPV: phase_reg <= PH_BLANK;
								SMS_ERASE: phase_reg <= PH_ERASE;
								SMS_PROG: phase_reg <= PH_PROG;
								default: phase_reg <= PH_VER;
							endcase
						end
					end
				end
				ST_RUN: begin
					if (op_done || op_fail) begin
						if (op_fail) begin
							err_reg <= 1'b1;
							state_reg <= ST_IDLE;
							phase_reg <= PH_NONE;
						end else if (phase_reg == PH_BLANK) phase_reg <= blank_ok ? PH_PROG : PH_ERASE;
						else if (phase_reg == PH_ERASE && mode_reg == SMS_EPV) phase_reg <= PH_PROG;
						else begin
							state_reg <= ST_IDLE;
							phase_reg <= PH_NONE;
						end
					end
				end
				ST_SIG, ST_RD: begin
					if (wait_reg == 8'(ACC_CYC)) begin
						wait_reg <= 8'h0;
						if (state_reg == ST_SIG) begin
							if (!rd_hi_reg) begin
								sig_reg[7:0] <= rom_data;
								rd_hi_reg <= 1'b1;
								rom_address <= 20'h1;
							end else if ({rom_data, sig_reg[7:0]} == SIG_EXPECT) begin
								sig_reg[15:8] <= rom_data;
								state_reg <= ST_RD;
								rom_address <= 20'h0;
								cnt_reg <= 20'h0;
							end else begin
								sig_reg[15:8] <= rom_data;
								err_reg <= 1'b1;
								state_reg <= ST_IDLE;
							end
						end else begin
							img_data <= rom_data;
							img_valid <= 1'b1;
							cnt_reg <= cnt_reg + 20'h1;
							rom_address <= size_reg == `SMS_SIZE_1M ? cnt_reg + 20'h1 : (cnt_reg + 20'h1) & `SMS_SMALL_MASK;
							if (last) begin
								loaded_reg <= 1'b1;
								state_reg <= ST_IDLE;
							end
						end
					end else wait_reg <= wait_reg + 8'h1;
				end
				default: begin
					// refused operation blinks error until next key
					if (enter_press || mode_press) state_reg <= ST_IDLE;
				end
			endcase
		end
	end
	assign rom_ce_n = !((state_reg == ST_SIG || state_reg == ST_RD) && wait_reg != 8'h0);
	assign rom_oe_n = rom_ce_n;
	assign access_led = state_reg == ST_SIG || state_reg == ST_RD;
	// request to the operation engine
	assign op_req = state_reg != ST_RUN ? 3'h0 : phase_reg == PH_BLANK ? 3'h1 : phase_reg == PH_ERASE ? 3'h2 :
		phase_reg == PH_PROG ? 3'h3 : 3'h4;

	// blink timer
	always_ff @(posedge clk) begin
		if (srst) begin
			blink_cnt_reg <= 20'h0;
			blink_reg <= 1'b0;
		end else if (blink_cnt_reg == 20'(BLINK_HALF)) begin
			blink_cnt_reg <= 20'h0;
			blink_reg <= ~blink_reg;
		end else blink_cnt_reg <= blink_cnt_reg + 20'h1;
	end
	// mode leds; one-hot selection, blinking while busy
	always_comb begin
		mode_led = 5'h0;
		mode_led[3'(mode_reg)] = (state_reg == ST_IDLE || state_reg == ST_ERR) ? 1'b1 : blink_reg;
	end
	assign error_led = state_reg == ST_ERR ? blink_reg : err_reg;

	// interrupts: set wins over write-one clear
	// byte taken on this edge; a bad signature is an error event
	assign sample_now = (state_reg == ST_SIG || state_reg == ST_RD) && wait_reg == 8'(ACC_CYC);
	assign sig_bad = sample_now && state_reg == ST_SIG && rd_hi_reg && {rom_data, sig_reg[7:0]} != SIG_EXPECT;
	assign ev = {state_reg == ST_ERR || (op_fail && state_reg == ST_RUN) || sig_bad,
		(state_reg == ST_RD && sample_now && last) || (state_reg == ST_RUN && op_done),
		load_go || (enter_press && state_reg == ST_IDLE)};
	always_ff @(posedge clk) begin
		if (srst) irq_reg <= 3'h0;
		else if (wr_fire && awaddr_reg == `SMS_OFF_IRQ) irq_reg <= (irq_reg & ~wdata_reg[2:0]) | ev;
		else irq_reg <= irq_reg | ev;
	end
	assign irq = |(irq_reg & ~mask_reg); // a set mask bit holds its event back

	// assertions
	a_reset_mode: assert property (@(posedge clk) srst |=> mode_reg == SMS_EPV) else $error("mode not epv");
	a_mode_ring: assert property (@(posedge clk) disable iff (srst) mode_press && state_reg == ST_IDLE &&
		mode_reg == SMS_LOAD |=> mode_reg == SMS_EPV) else $error("ring wrap wrong");
	a_refuse_write: assert property (@(posedge clk) disable iff (srst)
		state_reg == ST_IDLE && enter_press && !load_go && mode_reg != SMS_ERASE && mode_reg != SMS_LOAD &&
		!loaded_reg |=> state_reg == ST_ERR) else $error("no refusal");
	a_access_led: assert property (@(posedge clk) disable iff (srst) !rom_ce_n |-> access_led)
		else $error("access led off");
	a_load_led: assert property (@(posedge clk) disable iff (srst) mode_reg == SMS_LOAD |->
		mode_led[3:0] == 4'h0) else $error("other led lit");
	a_sig_first: assert property (@(posedge clk) disable iff (srst) load_go |=> state_reg == ST_SIG)
		else $error("signature skipped");
	a_enables_pair: assert property (@(posedge clk) disable iff (srst) rom_ce_n == rom_oe_n)
		else $error("enables split");
	a_addr_stable: assert property (@(posedge clk) disable iff (srst) !rom_ce_n && $past(!rom_ce_n) |->
		$stable(rom_address)) else $error("address moved");
	a_epv_blank: assert property (@(posedge clk) disable iff (srst) state_reg == ST_IDLE && enter_press &&
		!load_go && mode_reg == SMS_EPV && loaded_reg |=> phase_reg == PH_BLANK) else $error("no blank check");
	c_load: cover property (@(posedge clk) state_reg == ST_RD && last && wait_reg == 8'(ACC_CYC));
	c_err: cover property (@(posedge clk) state_reg == ST_ERR);
	c_epv: cover property (@(posedge clk) phase_reg == PH_ERASE && mode_reg == SMS_EPV);
endmodule

// ### hdl/sms_params.svh
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH
// register byte offsets
`define SMS_OFF_CTRL 12'h000
`define SMS_OFF_STAT 12'h004
`define SMS_OFF_IRQ 12'h008
`define SMS_OFF_MASK 12'h00C
`define SMS_OFF_SIG 12'h010
`define SMS_OFF_DONE 12'h014
`define SMS_OFF_LEN 12'h018
// ctrl fields (load is a write one pulse, size is stored)
`define SMS_CTRL_LOAD 0
`define SMS_CTRL_DONE 1
`define SMS_CTRL_FAIL 2
`define SMS_CTRL_SIZE_LO 4
`define SMS_CTRL_SIZE_HI 5
// irq bits
`define SMS_IRQ_START 0
`define SMS_IRQ_END 1
`define SMS_IRQ_ERR 2
`define SMS_IRQ_W 3
// socket sizes
`define SMS_SIZE_1M 2'h0
`define SMS_SIZE_512K 2'h1
`define SMS_SIZE_256K 2'h2
// small sockets leave the top two address lines unconnected
`define SMS_SMALL_MASK 20'h3FFFF
// reset values
`define SMS_SIG_RST 16'h0000
`define SMS_LEN_RST 20'h00100
// access timing
`define SMS_ACC_NS 150
`define SMS_CLK_MHZ 40
`define SMS_BLINK_HALF 20'hFFFFF
`endif

// ### hdl/sms_pkg.sv
package sms_pkg;
	typedef enum {SMS_EPV, SMS_ERASE, SMS_PROG, SMS_VERIFY, SMS_LOAD} sms_mode_t;
	typedef enum {ST_IDLE, ST_RUN, ST_SIG, ST_RD, ST_ERR} sms_state_t;
	typedef enum {PH_NONE, PH_BLANK, PH_ERASE, PH_PROG, PH_VER} sms_phase_t;
endpackage

// ### bench/sms_eprom_model.sv
`timescale 1ns/1ps
// ----
// eprom in the master socket
// ----
module sms_eprom_model (
	input wire logic clk,
	input wire logic [19:0] rom_address,
	input wire logic rom_ce_n,
	input wire logic rom_oe_n,
	input wire logic bad_sig,
	output logic [7:0] rom_data
);
	logic [7:0] last_reg;
	logic [7:0] val;
	// signature at 0 and 1, pattern elsewhere; top bits unused
	always_comb begin
		val = rom_address[17:0] == 0 ? 8'h5A : rom_address[7:0] ^ 8'h3C;
		if (rom_address[17:0] == 1)
			val = 8'hA5 ^ {8{bad_sig}};
	end
	// released bus shows a changing pattern
	always_ff @(posedge clk) last_reg <= rom_data;
	assign rom_data = (!rom_ce_n && !rom_oe_n) ? val : ~last_reg;
endmodule

// ### bench/standalone_mode_sequencer_bench.sv
`timescale 1ns/1ps
module standalone_mode_sequencer_bench;
	logic clk = 0, srst = 1, mode_key = 0, enter_key = 0, op_done = 0, op_fail = 0, blank_ok = 0, bad_sig = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic error_led, access_led, rom_ce_n, rom_oe_n, img_valid, irq, s_axi_bvalid, s_axi_rvalid;
	logic s_axi_awready, s_axi_wready, s_axi_arready;
	logic [4:0] mode_led;
	logic [5:0] leds;
	logic [19:0] rom_address, last_a;
	logic [7:0] rom_data, img_data;
	logic [2:0] op_req;
	logic [2:0] seq [6];
	logic [1:0] s_axi_bresp, s_axi_rresp, sn;
	int n_errors = 0, n_compared = 0, low_n = 0, img_i = 0, j, k;
	assign leds = {error_led, mode_led};
	sms_sequencer #(.BLINK_HALF(4)) sms_sequencer_i (.clk(clk), .srst(srst), .mode_key(mode_key),
		.enter_key(enter_key), .mode_led(mode_led), .error_led(error_led), .access_led(access_led),
		.rom_address(rom_address), .rom_ce_n(rom_ce_n), .rom_oe_n(rom_oe_n), .rom_data(rom_data),
		.img_data(img_data), .img_valid(img_valid), .op_req(op_req), .op_done(op_done), .op_fail(op_fail),
		.blank_ok(blank_ok), .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	sms_eprom_model sms_eprom_model_i (.clk(clk), .rom_address(rom_address), .rom_ce_n(rom_ce_n),
		.rom_oe_n(rom_oe_n), .bad_sig(bad_sig), .rom_data(rom_data));
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// ----
	// tasks
	// ----
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	task give_verdict;
		if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task tmo(input string nm);
		chk(nm, 1, 0);
		give_verdict();
	endtask
	task do_reset;
		@(posedge clk);
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		@(negedge clk);
	endtask
	// one axi access, read data lands in q
	task axi(input bit wr, input logic [11:0] a, input logic [31:0] d);
		bit ta, tw, tb, tr;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready === 1'b1;
			tw = s_axi_wvalid && s_axi_wready === 1'b1;
			tb = s_axi_bready && !s_axi_awvalid && !s_axi_wvalid && s_axi_bvalid === 1'b1;
			tr = s_axi_rready && !s_axi_arvalid && s_axi_rvalid === 1'b1;
			if (tr) q = s_axi_rdata;
			if (tr) chk("rresp", 0, s_axi_rresp);
			if (tb) chk("bresp", 0, s_axi_bresp);
			@(posedge clk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
			if (tb) s_axi_bready <= 0;
			if (tr) s_axi_rready <= 0;
			if (tb || tr) return;
		end
		tmo("axi");
	endtask
	task press(input bit ent);
		@(posedge clk);
		if (ent) enter_key <= 1;
		else mode_key <= 1;
		repeat (2) @(posedge clk);
		enter_key <= 0;
		mode_key <= 0;
		repeat (3) @(posedge clk);
	endtask
	// levels seen on one led over 30 cycles
	task watch(input int b, output logic [1:0] s);
		s = 0;
		repeat (30) begin
			@(negedge clk);
			if (leds[b] === 1'b1) s[1] = 1;
			if (leds[b] === 1'b0) s[0] = 1;
		end
	endtask
	// rom strobe timing and loaded byte stream
	always @(negedge clk) begin
		if (srst === 1'b0 && rom_ce_n === 1'b0) begin
			low_n++;
			if (low_n > 1) chk("addr hold", last_a, rom_address);
			chk("access led", 1, access_led);
			chk("oe with ce", 0, rom_oe_n);
		end else if (low_n > 0) begin
			chk("strobe len", 6, low_n);
			low_n = 0;
		end
		last_a = rom_address;
		if (img_valid === 1'b1) begin
			chk("img byte", img_i == 0 ? 8'h5A : img_i == 1 ? 8'hA5 : img_i[7:0] ^ 8'h3C, img_data);
			img_i++;
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		do_reset();
		chk("mode led", 1, mode_led);
		axi(0, 12'h004, 0);
		chk("stat", 0, q & 32'hFF);
		axi(0, 12'h010, 0);
		chk("sig rst", 0, q);
		axi(0, 12'h018, 0);
		chk("len rst", 32'h100, q);
		axi(1, 12'hFFC, 32'h5);
		axi(0, 12'hFFC, 0);
		chk("unmapped", 0, q);
		axi(1, 12'h000, 32'h10);
		axi(0, 12'h000, 0);
		chk("size", 32'h10, q);
		press(1);
		watch(5, sn);
		chk("err blink", 3, sn);
		chk("op refused", 0, op_req);
		do_reset();
		chk("mode led", 1, mode_led);
		axi(1, 12'h018, 4);
		axi(1, 12'h00C, 0);
		for (int i = 1; i < 5; i++) begin
			press(0);
			chk("mode ring", 1 << i, mode_led);
		end
		press(1);
		for (k = 0; k < 400 && img_i < 4; k++) @(negedge clk);
		repeat (20) @(negedge clk);
		chk("bytes", 4, img_i);
		axi(0, 12'h004, 0);
		chk("stat", 32'h44, q & 32'hFF);
		axi(0, 12'h010, 0);
		chk("sig", 32'hA55A, q);
		axi(0, 12'h008, 0);
		chk("irq bits", 3, q & 32'h7);
		chk("irq", 1, irq);
		axi(1, 12'h00C, 7);
		chk("irq masked", 0, irq);
		axi(1, 12'h008, 7);
		axi(1, 12'h00C, 0);
		axi(0, 12'h008, 0);
		chk("irq clr", 0, q & 32'h7);
		chk("irq low", 0, irq);
		press(0);
		chk("mode wrap", 1, mode_led);
		press(1);
		for (j = 0; j < 6; j++) begin
			for (k = 0; k < 60 && op_req === 3'h0; k++) @(negedge clk);
			if (op_req === 3'h0) break;
			seq[j] = op_req;
			if (j == 0) watch(0, sn);
			if (j == 0) chk("run blink", 3, sn);
			@(posedge clk);
			op_done <= 1;
			@(posedge clk);
			op_done <= 0;
			repeat (3) @(negedge clk);
		end
		chk("op seq", {3'h1, 3'h2, 3'h3}, {seq[0], seq[1], seq[2]});
		// blank target skips erase; a failing step stops with the error led
		@(posedge clk);
		blank_ok <= 1;
		press(1);
		@(negedge clk);
		chk("blank first", 3'h1, op_req);
		@(posedge clk);
		op_done <= 1;
		@(posedge clk);
		op_done <= 0;
		@(negedge clk);
		chk("no erase", 3'h3, op_req);
		@(posedge clk);
		op_fail <= 1;
		@(posedge clk);
		op_fail <= 0;
		@(negedge clk);
		chk("fail led", 1, error_led);
		chk("fail stop", 0, op_req);
		axi(0, 12'h008, 0);
		chk("irq fail", 4, q & 32'h4);
		axi(1, 12'h008, 7);
		@(posedge clk);
		bad_sig <= 1;
		axi(1, 12'h000, 1);
		repeat (60) @(negedge clk);
		chk("err led", 1, error_led);
		chk("no bytes", 4, img_i);
		axi(0, 12'h008, 0);
		chk("irq err", 4, q & 32'h4);
		give_verdict();
	end
endmodule
